// ### pfc_pwm_timer.sv
// dual-slope phase and frequency correct pwm timer with apb registers
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pfc_pwm_timer #(
  parameter int W = 16  // counter width
) (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  output logic PWM_A_O,
  output logic PWM_A_OE_O,
  output logic PWM_B_O,
  output logic PWM_B_OE_O
);
  // ****************************************
  // bus decode
  // ****************************************
  pfc_pwm_pkg::apb_req_t req;   // bundled request
  pfc_pwm_pkg::ctrl_t ctrl;     // control register
  logic [W-1:0] capture_top_reg;
  logic [3:0] flags;            // sticky status
  logic [3:0] irq_mask;
  logic [31:0] next_rdata;
  logic next_slverr;
  wire setup = PSEL_I & ~PENABLE_I;     // read data is latched here
  wire wr_go = PSEL_I & PENABLE_I & PWRITE_I;
  wire hit_ctrl = req.paddr == pfc_pwm_pkg::OFS_CTRL;
  wire hit_count = req.paddr == pfc_pwm_pkg::OFS_COUNT;
  wire hit_cmpa = req.paddr == pfc_pwm_pkg::OFS_CMP_A;
  wire hit_cmpb = req.paddr == pfc_pwm_pkg::OFS_CMP_B;
  wire hit_cap = req.paddr == pfc_pwm_pkg::OFS_CAPTOP;
  wire hit_stat = req.paddr == pfc_pwm_pkg::OFS_STATUS;
  wire hit_mask = req.paddr == pfc_pwm_pkg::OFS_MASK;
  wire hit_any = hit_ctrl | hit_count | hit_cmpa | hit_cmpb | hit_cap | hit_stat | hit_mask;
  assign req = '{paddr: PADDR_I, pwrite: PWRITE_I, pwdata: PWDATA_I};
  // zero wait states: every access completes in its first access cycle
  assign PREADY_O = 1'b1;

  // ****************************************
  // prescaler
  // ****************************************
  logic [9:0] pre_cnt;          // free-running divider
  logic tick;                   // timer_tick
  wire [2:0] cs = ctrl.clock_sel;
  // a span ends when its low bits are all ones
  assign tick =
    (cs == pfc_pwm_pkg::CS_DIV1) ? 1'b1 :
    (cs == pfc_pwm_pkg::CS_DIV8) ? &(pre_cnt | ~pfc_pwm_pkg::MASK_DIV8) :
    (cs == pfc_pwm_pkg::CS_DIV64) ? &(pre_cnt | ~pfc_pwm_pkg::MASK_DIV64) :
    (cs == pfc_pwm_pkg::CS_DIV256) ? &(pre_cnt | ~pfc_pwm_pkg::MASK_DIV256) :
    (cs == pfc_pwm_pkg::CS_DIV1024) ? &(pre_cnt | ~pfc_pwm_pkg::MASK_DIV1024) :
    1'b0;
  // divider keeps running; changing the divide ratio may cut one span short
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) pre_cnt <= 10'h000;
    else pre_cnt <= pre_cnt + 10'h001;
  end

  // ****************************************
  // counter and slope
  // ****************************************
  logic [W-1:0] counter_value;
  logic [W-1:0] next_counter;
  logic dir_up;                 // rising slope
  logic next_dir_up;
  logic [W-1:0] top_value;
  logic [W-1:0] cmp_a_active;
  logic [W-1:0] cmp_b_active;
  logic [W-1:0] cmp_a_buf;
  logic [W-1:0] cmp_b_buf;
  logic match_a;
  logic match_b;
  logic level_a;
  logic level_b;
  wire [3:0] wm = ctrl.waveform_mode_sel;
  wire mode_cap = wm == pfc_pwm_pkg::WM_PFC_CAPTOP;
  wire mode_cmpa = wm == pfc_pwm_pkg::WM_PFC_CMPA;
  wire running = mode_cap | mode_cmpa;
  wire step = tick & running;
  assign top_value = mode_cap ? capture_top_reg : cmp_a_active;
  wire at_zero = counter_value == '0;
  wire past_top = counter_value >= top_value;
  // a top below the count still reverses rather than wrapping
  wire top_evt = step & dir_up & past_top;
  wire bottom_evt = step & ~dir_up & at_zero;
  // at bottom the match counts as rising, at top as falling, so
  // a non-inverting compare at zero holds low and one at top holds high
  wire going_up = at_zero | (dir_up & ~past_top);
  assign next_counter =
    ~step ? counter_value :
    (dir_up & past_top) ? counter_value - 1'b1 :
    (~dir_up & ~at_zero) ? counter_value - 1'b1 :
    counter_value + 1'b1;
  assign next_dir_up =
    top_evt ? 1'b0 :
    bottom_evt ? 1'b1 :
    dir_up;
  // reset in the falling state so the first tick is a bottom and loads
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      counter_value <= '0;
      dir_up <= 1'b0;
    end else begin
      counter_value <= next_counter;
      dir_up <= next_dir_up;
    end
  end

  // ****************************************
  // compare channels
  // ****************************************
  pfc_channel #(.W(W)) u_chan_a (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .tick_i(tick),
    .pwm_mode_i(running),
    .buf_we_i(wr_go & hit_cmpa),
    .buf_data_i(req.pwdata[W-1:0]),
    .load_i(bottom_evt),
    .count_i(counter_value),
    .going_up_i(going_up),
    .out_mode_i(ctrl.output_mode_sel_a),
    .toggle_ok_i(mode_cmpa),
    .active_o(cmp_a_active),
    .buffer_o(cmp_a_buf),
    .match_o(match_a),
    .level_o(level_a)
  );
  pfc_channel #(.W(W)) u_chan_b (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .tick_i(tick),
    .pwm_mode_i(running),
    .buf_we_i(wr_go & hit_cmpb),
    .buf_data_i(req.pwdata[W-1:0]),
    .load_i(bottom_evt),
    .count_i(counter_value),
    .going_up_i(going_up),
    .out_mode_i(ctrl.output_mode_sel_b),
    .toggle_ok_i(1'b0),
    .active_o(cmp_b_active),
    .buffer_o(cmp_b_buf),
    .match_o(match_b),
    .level_o(level_b)
  );

  // ****************************************
  // pins
  // ****************************************
  // a channel in normal port mode or an input pin is not driven
  assign PWM_A_OE_O = ctrl.pin_direction_bit[0] &
    (ctrl.output_mode_sel_a != pfc_pwm_pkg::OM_OFF);
  assign PWM_B_OE_O = ctrl.pin_direction_bit[1] &
    (ctrl.output_mode_sel_b != pfc_pwm_pkg::OM_OFF);
  assign PWM_A_O = level_a;
  assign PWM_B_O = level_b;

  // ****************************************
  // flags and interrupt
  // ****************************************
  logic [3:0] events;
  logic [3:0] next_flags;
  assign events[pfc_pwm_pkg::ST_OVF] = bottom_evt;
  assign events[pfc_pwm_pkg::ST_CAP] = top_evt & mode_cap;
  assign events[pfc_pwm_pkg::ST_MA] = match_a | (top_evt & mode_cmpa);
  assign events[pfc_pwm_pkg::ST_MB] = match_b;
  wire [3:0] clr = (wr_go & hit_stat) ? req.pwdata[3:0] : 4'h0;
  // an event in the clearing cycle survives the clear
  assign next_flags = (flags & ~clr) | events;
  assign IRQ_O = |(flags & irq_mask);
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) flags <= pfc_pwm_pkg::FLAGS_RST;
    else flags <= next_flags;
  end

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl <= pfc_pwm_pkg::CTRL_RST;
      capture_top_reg <= pfc_pwm_pkg::CAPTOP_RST;
      irq_mask <= 4'h0;
    end else if (wr_go) begin
      if (hit_ctrl) ctrl <= req.pwdata[pfc_pwm_pkg::CTRL_W-1:0];
      // capture-top is single buffered: a change lands at once
      if (hit_cap) capture_top_reg <= req.pwdata[W-1:0];
      if (hit_mask) irq_mask <= req.pwdata[3:0];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // compare locations read back the buffer, the value last written
  assign next_rdata =
    hit_ctrl ? {19'h00000, ctrl} :
    hit_count ? 32'(counter_value) :
    hit_cmpa ? 32'(cmp_a_buf) :
    hit_cmpb ? 32'(cmp_b_buf) :
    hit_cap ? 32'(capture_top_reg) :
    hit_stat ? {28'h0000000, flags} :
    hit_mask ? {28'h0000000, irq_mask} :
    32'h00000000;
  assign next_slverr = ~hit_any;
  // latched in setup, so data and error stand through the access cycle
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else if (setup) begin
      PRDATA_O <= req.pwrite ? 32'h00000000 : next_rdata;
      PSLVERR_O <= next_slverr;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_IDLE_OUTSIDE_MODE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    !running |=> counter_value == $past(counter_value))
    else $error("counter moved outside the pwm modes");
  AST_RISE_STEP: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    step && dir_up && !past_top |=> counter_value == $past(counter_value) + 1'b1)
    else $error("rising slope did not step by one");
  AST_TOP_TURN: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    top_evt |=> !dir_up && counter_value == $past(counter_value) - 1'b1)
    else $error("counter did not turn at top");
  AST_TICK_ONLY: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    !tick |=> $stable(counter_value) && $stable(dir_up))
    else $error("counter changed without a tick");
  AST_TOP_ONE_TICK: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    step && dir_up && counter_value + 1'b1 == top_value
    |=> counter_value == $past(top_value) && dir_up)
    else $error("counter did not land on top with the rising slope");
  AST_BOTTOM_LOAD: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    bottom_evt |=> cmp_b_active == $past(cmp_b_buf) && flags[pfc_pwm_pkg::ST_OVF])
    else $error("bottom did not load compare or set overflow");
  AST_BOTTOM_REVERSE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    bottom_evt |=> dir_up && counter_value == 1)
    else $error("bottom did not restart the rising slope");
  AST_MATCH_FLAG: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    step && counter_value == cmp_b_active |=> flags[pfc_pwm_pkg::ST_MB])
    else $error("compare b match flag not set");
  AST_CAPTOP_FLAG: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    top_evt && mode_cap |=> flags[pfc_pwm_pkg::ST_CAP])
    else $error("capture flag not set at top");
  AST_PIN_GATED: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    !ctrl.pin_direction_bit[0] |-> !PWM_A_OE_O)
    else $error("pin a driven while set as input");
  AST_DIV8: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
    cs == pfc_pwm_pkg::CS_DIV8 && tick |=> !tick [*7])
    else $error("divide by eight tick spacing wrong");
  COV_TOP: cover property (@(posedge CLOCK_I) top_evt);
  COV_BOTTOM: cover property (@(posedge CLOCK_I) bottom_evt ##[1:12] bottom_evt);
  COV_MATCH_A: cover property (@(posedge CLOCK_I) match_a && going_up);
  COV_IRQ: cover property (@(posedge CLOCK_I) $rose(IRQ_O));
endmodule

// ### pfc_pwm_pkg.sv
// shared constants and types for the dual-slope pwm timer
package pfc_pwm_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;    // mode, prescaler, outputs
  localparam logic [7:0] OFS_COUNT = 8'h04;   // counter value, read only
  localparam logic [7:0] OFS_CMP_A = 8'h08;   // compare a buffer
  localparam logic [7:0] OFS_CMP_B = 8'h0C;   // compare b buffer
  localparam logic [7:0] OFS_CAPTOP = 8'h10;  // capture-top register
  localparam logic [7:0] OFS_STATUS = 8'h14;  // sticky flags, write one clears
  localparam logic [7:0] OFS_MASK = 8'h18;    // interrupt mask
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_W = 13;                 // used control bits
  localparam logic [12:0] CTRL_RST = 13'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CAPTOP_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam int ST_OVF = 0;                  // overflow_flag
  localparam int ST_CAP = 1;                  // capture_flag
  localparam int ST_MA = 2;                   // compare_match_flag a
  localparam int ST_MB = 3;                   // compare_match_flag b
  // ****************************************
  // mode encodings
  // ****************************************
  localparam logic [3:0] WM_PFC_CAPTOP = 4'h8; // top from capture-top
  localparam logic [3:0] WM_PFC_CMPA = 4'h9;   // top from compare a
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_NONINV = 2'h2;
  localparam logic [1:0] OM_INV = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] MASK_DIV8 = 10'h007;  // low bits all ones ends a span
  localparam logic [9:0] MASK_DIV64 = 10'h03F;
  localparam logic [9:0] MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] pin_direction_bit;  // [12:11] b, a
    logic [1:0] output_mode_sel_b;  // [10:9]
    logic [1:0] output_mode_sel_a;  // [8:7]
    logic [2:0] clock_sel;          // [6:4]
    logic [3:0] waveform_mode_sel;  // [3:0]
  } ctrl_t;
  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// ### pfc_channel.sv
// one compare channel: buffered compare value, match detect, output level
`timescale 1ns/1ps
module pfc_channel #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tick_i,            // timer tick enable
  input wire logic pwm_mode_i,        // dual-slope mode active
  input wire logic buf_we_i,          // software write to buffer
  input wire logic [W-1:0] buf_data_i,
  input wire logic load_i,            // bottom reached this tick
  input wire logic [W-1:0] count_i,
  input wire logic going_up_i,        // effective slope for outputs
  input wire logic [1:0] out_mode_i,
  input wire logic toggle_ok_i,       // toggle allowed on this channel
  output logic [W-1:0] active_o,
  output logic [W-1:0] buffer_o,
  output logic match_o,               // one-cycle match event
  output logic level_o                // compare_output
);
  // ****************************************
  // match and next values
  // ****************************************
  logic [W-1:0] next_active;
  logic next_level;
  assign match_o = tick_i & pwm_mode_i & (count_i == active_o);
  // in the pwm modes the active copy moves only at bottom, so both slopes see one value
  assign next_active = (load_i | ~pwm_mode_i) ? buffer_o : active_o;
  // non-inverting clears rising, sets falling; inverting the reverse
  assign next_level =
    ~match_o ? level_o :
    (out_mode_i == pfc_pwm_pkg::OM_NONINV) ? ~going_up_i :
    (out_mode_i == pfc_pwm_pkg::OM_INV) ? going_up_i :
    (out_mode_i == pfc_pwm_pkg::OM_TOGGLE && toggle_ok_i) ? ~level_o :
    level_o;
  // ****************************************
  // registers
  // ****************************************
  // software lands in the buffer only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buffer_o <= '0;
      active_o <= '0;
      level_o <= 1'b0;
    end else begin
      if (buf_we_i) buffer_o <= buf_data_i;
      active_o <= next_active;
      level_o <= next_level;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  AST_NONINV_UP_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    match_o && going_up_i && out_mode_i == pfc_pwm_pkg::OM_NONINV |=> !level_o)
    else $error("non-inverting match on rise did not clear output");
  AST_INV_DOWN_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    match_o && !going_up_i && out_mode_i == pfc_pwm_pkg::OM_INV |=> !level_o)
    else $error("inverting match on fall did not clear output");
  AST_BUFFER_ONLY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    buf_we_i && pwm_mode_i && !load_i |=> active_o == $past(active_o))
    else $error("write reached the active compare value directly");
endmodule

// ### pwm_load_model.sv
// load model standing on the two pwm pins of the timer
`timescale 1ns/1ps
module pwm_load_model (
  input wire logic pwm_a_i,   // pin level offered by channel a
  input wire logic oe_a_i,    // channel a drives its pin
  input wire logic pwm_b_i,   // pin level offered by channel b
  input wire logic oe_b_i,    // channel b drives its pin
  output logic line_a_o,      // level seen on the wire a
  output logic line_b_o       // level seen on the wire b
);
  // ****************************************
  // wire levels
  // ****************************************
  // an undriven pin sinks through the load's pull-down, never keeps the last level
  assign line_a_o = oe_a_i ? pwm_a_i : 1'b0;
  assign line_b_o = oe_b_i ? pwm_b_i : 1'b0;
endmodule

// ### tb_dual_slope_freq_correct_pwm.sv
// self-checking testbench for the dual-slope pwm timer
`timescale 1ns/1ps
module tb_dual_slope_freq_correct_pwm;
  // ****************************************
  // stimulus and observation signals
  // ****************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, pwm_a, oe_a, pwm_b, oe_b, line_a, line_b;
  logic [31:0] rd;       // last read data
  logic er;              // last error response
  int hi_a, hi_b;        // high cycles seen on each wire
  int n_fail = 0;
  int n_compared = 0;
  localparam logic [1:0] NI = pfc_pwm_pkg::OM_NONINV;
  localparam logic [1:0] IV = pfc_pwm_pkg::OM_INV;
  // output polarity table: modes, compares, expected highs per 12 ticks
  logic [1:0] t_oa [3] = '{NI, IV, NI};
  logic [1:0] t_ob [3] = '{IV, NI, IV};
  logic [31:0] t_ca [3] = '{32'h1, 32'h1, 32'h0};
  logic [31:0] t_cb [3] = '{32'h3, 32'h3, 32'h0};
  int t_ea [3] = '{4, 8, 0};
  int t_eb [3] = '{0, 12, 12};
  int nd [5] = '{1, 8, 64, 256, 1024};
  logic [2:0] t_cs [5] = '{pfc_pwm_pkg::CS_DIV1, pfc_pwm_pkg::CS_DIV8, pfc_pwm_pkg::CS_DIV64,
    pfc_pwm_pkg::CS_DIV256, pfc_pwm_pkg::CS_DIV1024};
  // ****************************************
  // clock, design and load
  // ****************************************
  always #12.5 clk = ~clk;
  pfc_pwm_timer u_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .PWM_A_O(pwm_a),
    .PWM_A_OE_O(oe_a), .PWM_B_O(pwm_b), .PWM_B_OE_O(oe_b));
  pwm_load_model u_load (.pwm_a_i(pwm_a), .oe_a_i(oe_a), .pwm_b_i(pwm_b), .oe_b_i(oe_b),
    .line_a_o(line_a), .line_b_o(line_b));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask
  // counts high cycles over a whole number of periods, so phase does not matter
  task automatic count_hi(input int n);
    hi_a = 0;
    hi_b = 0;
    repeat (n) begin
      @(posedge clk);
      hi_a += int'(line_a === 1'b1);
      hi_b += int'(line_b === 1'b1);
    end
  endtask
  function automatic logic [31:0] cw(input logic [3:0] wm, input logic [2:0] cs,
    input logic [1:0] oa, input logic [1:0] ob, input logic [1:0] dv);
    pfc_pwm_pkg::ctrl_t c;
    c = '{pin_direction_bit: dv, output_mode_sel_b: ob, output_mode_sel_a: oa,
      clock_sel: cs, waveform_mode_sel: wm};
    return 32'(c);
  endfunction
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(pfc_pwm_pkg::OFS_CTRL, 32'h00000000);
    rdchk(pfc_pwm_pkg::OFS_STATUS, 32'h00000000);
    rdchk(pfc_pwm_pkg::OFS_MASK, 32'h00000000);
    apb(1'b0, 8'h1C, 32'h00000000);
    check(rd, 32'h00000000);
    check({31'h0, er}, 32'h00000001);
    wr(pfc_pwm_pkg::OFS_CAPTOP, 32'h00000003);
    wr(pfc_pwm_pkg::OFS_CMP_A, 32'h00000001);
    rdchk(pfc_pwm_pkg::OFS_CMP_A, 32'h00000001);
    // polarity and extreme compare values, top from capture-top
    for (int i = 0; i < 3; i++) begin
      wr(pfc_pwm_pkg::OFS_CMP_A, t_ca[i]);
      wr(pfc_pwm_pkg::OFS_CMP_B, t_cb[i]);
      wr(pfc_pwm_pkg::OFS_CTRL, cw(pfc_pwm_pkg::WM_PFC_CAPTOP, pfc_pwm_pkg::CS_DIV1,
        t_oa[i], t_ob[i], 2'h3));
      repeat (24) @(posedge clk);
      count_hi(12);
      check(32'(hi_a), 32'(t_ea[i]));
      check(32'(hi_b), 32'(t_eb[i]));
    end
    check({31'h0, oe_a}, 32'h00000001);
    // each of the five dividing prescaler settings stretches the period by its divisor
    wr(pfc_pwm_pkg::OFS_CMP_A, 32'h00000001);
    for (int i = 0; i < 5; i++) begin
      wr(pfc_pwm_pkg::OFS_CTRL, cw(pfc_pwm_pkg::WM_PFC_CAPTOP, t_cs[i], NI, NI, 2'h3));
      repeat (12 * nd[i]) @(posedge clk);
      count_hi(12 * nd[i]);
      check(32'(hi_a), 32'(4 * nd[i]));
    end
    // compare a as top with toggle on channel a
    wr(pfc_pwm_pkg::OFS_CMP_A, 32'h00000003);
    wr(pfc_pwm_pkg::OFS_CMP_B, 32'h00000001);
    wr(pfc_pwm_pkg::OFS_CTRL, cw(pfc_pwm_pkg::WM_PFC_CMPA, pfc_pwm_pkg::CS_DIV1,
      pfc_pwm_pkg::OM_TOGGLE, NI, 2'h3));
    repeat (24) @(posedge clk);
    count_hi(12);
    check(32'(hi_a), 32'h00000006);
    check(32'(hi_b), 32'h00000004);
    // flags after a clean start, then stop the tick so they stay put
    wr(pfc_pwm_pkg::OFS_STATUS, 32'h0000000F);
    repeat (24) @(posedge clk);
    wr(pfc_pwm_pkg::OFS_CTRL, cw(pfc_pwm_pkg::WM_PFC_CMPA, pfc_pwm_pkg::CS_STOP,
      pfc_pwm_pkg::OM_TOGGLE, NI, 2'h3));
    rdchk(pfc_pwm_pkg::OFS_STATUS, 32'h0000000D);
    wr(pfc_pwm_pkg::OFS_MASK, 32'h00000000);
    @(negedge clk);
    check({31'h0, irq}, 32'h00000000);
    wr(pfc_pwm_pkg::OFS_MASK, 32'h00000001);
    @(negedge clk);
    check({31'h0, irq}, 32'h00000001);
    wr(pfc_pwm_pkg::OFS_STATUS, 32'h00000001);
    @(negedge clk);
    check({31'h0, irq}, 32'h00000000);
    rdchk(pfc_pwm_pkg::OFS_STATUS, 32'h0000000C);
    // pin released when its direction bit is clear
    wr(pfc_pwm_pkg::OFS_CTRL, cw(pfc_pwm_pkg::WM_PFC_CAPTOP, pfc_pwm_pkg::CS_DIV1,
      NI, NI, 2'h0));
    @(negedge clk);
    check({31'h0, oe_a}, 32'h00000000);
    check({31'h0, oe_b}, 32'h00000000);
    count_hi(12);
    check(32'(hi_a), 32'h00000000);
    // capture-top as top: every flag reads set, overflow and capture set again
    rdchk(pfc_pwm_pkg::OFS_STATUS, 32'h0000000F);
    // outside the two pwm modes the counter stands still
    wr(pfc_pwm_pkg::OFS_CTRL, cw(4'h0, pfc_pwm_pkg::CS_DIV1, NI, NI, 2'h3));
    apb(1'b0, pfc_pwm_pkg::OFS_COUNT, 32'h00000000);
    hi_a = int'(rd);
    repeat (10) @(posedge clk);
    rdchk(pfc_pwm_pkg::OFS_COUNT, 32'(hi_a));
    conclude();
  end
  // watchdog: the sequence needs about 33000 cycles
  initial begin
    #1500000;
    n_fail++;
    conclude();
  end
endmodule
